// ### rtl/snce_pkg.sv
package snce_pkg;
  // Functional notes
  // [R1] Page holds 2048 main plus 128 spare bytes; moved as whole units
  // [R2] Error correction comes up enabled; software may clear the enable
  // [R3] Correction on: only first 64 spare bytes programmable, all readable
  // [R4] Correction off: all 128 spare bytes readable and programmable
  // [R5] Correction on: program computes and stores check codes itself
  // [R6] Correction on: page load checks codewords and reports a status
  // [R7] Each codeword covers 528 bytes of page content
  // [R8] After reset page zero of block zero loads into the cache
  // [R9] Reads and programs work on one page, erase on one block
  // [R10] Data register faces the array, cache register faces the link
  // [R11] Internal move copies a page between rows without the host
  // [R12] Cache read and cache program overlap link and array work; only cache read exists here, no cache program
  // [R13] Four-lane frames use lines 2 and 3 as data, else control
  // [R14] Page load into cache finishes within 80 microseconds
  // [R15] Program takes about 400 us, block erase about 3 ms
  // [R16] Status register shows progress and outcome of operations
  // [R17] Column address 12 bits; bytes above 2175 are out of bounds
  // [R18] Row bits 5:0 select page, bits 15:6 select block
  // [R19] Busy shows for the whole of any array operation

  localparam int MAIN_BYTES = 2048;
  localparam int SPARE_BYTES = 128;
  localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
  localparam int ECC_PROG_SPARE = 64;
  localparam int CW_BYTES = 528;
  localparam int CW_COUNT = 4;
  localparam int CHECK_BASE = CW_BYTES * CW_COUNT;
  localparam int LAST_COL = PAGE_BYTES - 1;
  localparam int COL_W = 12;
  localparam int ROW_W = 16;
  localparam int PAGE_SEL_W = 6;
  localparam int PAGES_PER_BLOCK = 64;

  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 400;
  localparam int ERASE_TIME_MS = 3;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_MS * 1000 * CLK_MHZ;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ROW = 8'h08;
  localparam logic [7:0] REG_DEST = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR = 8'h18;
  localparam logic [7:0] REG_IRQ_EN = 8'h1c;

  localparam logic CTRL_ECC_RESET = 1'b1;
  localparam int ST_BUSY = 0;
  localparam int ST_CBUSY = 1;
  localparam int ST_ECC = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ECC = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [1:0] ECC_OK = 2'h0;
  localparam logic [1:0] ECC_FAIL = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_CACHE_READ = 3'h2,
    OP_PROGRAM = 3'h3,
    OP_ERASE = 3'h4,
    OP_MOVE = 3'h5
  } snce_op_t;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_A2D = 3'b001,
    E_D2C = 3'b011,
    E_C2D = 3'b010,
    E_D2A = 3'b110,
    E_WAIT = 3'b111,
    E_ERASE = 3'b101
  } snce_eng_t;

  typedef enum logic [1:0] {
    L_HDR = 2'b00,
    L_ADDR = 2'b01,
    L_DATA = 2'b11
  } snce_lph_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } snce_pins_t;
endpackage

// ### rtl/snce_core.sv
`timescale 1ns/1ps
module snce_core #(
  parameter int ARRAY_PAGES = 4,
  parameter int PROG_CYCLES = snce_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = snce_pkg::ERASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Interrupt
  output logic irq
);
  import snce_pkg::*;

  localparam int PAW = $clog2(ARRAY_PAGES);

  typedef struct packed {
    snce_pins_t s1;
    snce_pins_t s2;
    snce_pins_t s3;
    logic ecc_en;
    logic [ROW_W-1:0] row;
    logic [ROW_W-1:0] dest;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    snce_eng_t st;
    snce_op_t op;
    logic [ROW_W-1:0] cur_row;
    logic [COL_W-1:0] idx;
    logic [9:0] cw_pos;
    logic [1:0] cw;
    logic [7:0] acc;
    logic [CW_COUNT-1:0][7:0] chk;
    logic ecc_bad;
    logic [1:0] ecc_stat;
    logic [31:0] timer;
    logic [PAGE_SEL_W-1:0] epg;
    snce_lph_t lph;
    logic [7:0] hdr;
    logic lwrite;
    logic [1:0] wmode;
    logic [4:0] lbits;
    logic [COL_W-1:0] col;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [3:0] obits;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [PAGE_BYTES-1:0][7:0] cache;
    logic [PAGE_BYTES-1:0][7:0] dreg;
    logic [ARRAY_PAGES-1:0][PAGE_BYTES-1:0][7:0] mem;
  } snce_state_t;

  snce_state_t q;
  snce_state_t n;

  logic busy;
  logic cbusy;
  logic wr_acc;
  logic unmapped;

  assign busy = (q.st != E_IDLE);
  assign cbusy = (q.st == E_D2C) || (q.st == E_C2D);
  assign wr_acc = psel && penable && pwrite;
  assign unmapped = (paddr > REG_IRQ_EN) || (paddr[1:0] != 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = q.rdata;
  assign io_out = q.io_out;
  assign io_oe = q.io_oe;
  assign irq = |(q.irq_stat & q.irq_en);

  always_comb
  begin
    int k;
    logic [PAW-1:0] pg;
    logic [ROW_W-1:0] erow;
    logic [7:0] b;
    logic [7:0] acc;
    logic last;
    logic cw_end;
    logic in_cw;
    logic done;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [31:0] rv;
    logic rise;
    logic fall;
    logic hold;
    logic [3:0] wbits;
    logic [7:0] sh;
    logic [4:0] nb;
    k = 0;
    pg = q.cur_row[PAW-1:0];
    erow = {q.cur_row[ROW_W-1:PAGE_SEL_W], q.epg}; // R18
    b = 8'h00;
    acc = 8'h00;
    last = (q.idx == COL_W'(LAST_COL));
    cw_end = (q.cw_pos == 10'(CW_BYTES - 1));
    in_cw = (q.idx < COL_W'(CHECK_BASE));
    done = 1'b0;
    ev = '0;
    clr = '0;
    rv = 32'h0;
    sh = 8'h00;
    nb = 5'h00;
    n = q;

    // Input synchronisers and edge detection on the link
    n.s1 = '{sclk: sclk, cs_n: cs_n, io: io_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    rise = q.s2.sclk && !q.s3.sclk;
    fall = !q.s2.sclk && q.s3.sclk;
    hold = !q.s2.io[3] && (q.wmode != 2'h2); // R13
    unique case (q.wmode)
      2'h1: wbits = 4'h2;
      2'h2: wbits = 4'h4;
      default: wbits = 4'h1;
    endcase

    // Array engine
    if (q.timer != 32'h0)
      n.timer = q.timer - 32'h1;
    if (q.st == E_A2D || q.st == E_D2C || q.st == E_C2D || q.st == E_D2A)
    begin
      n.idx = last ? '0 : q.idx + 12'h001; // R1 R9
      if (in_cw)
      begin
        n.cw_pos = cw_end ? 10'h000 : q.cw_pos + 10'h001; // R7
        n.cw = cw_end ? q.cw + 2'h1 : q.cw;
      end
    end
    unique case (q.st)
      E_IDLE:
      begin
      end
      E_A2D:
      begin
        b = q.mem[pg][q.idx];
        n.dreg[q.idx] = b; // R10
        if (in_cw)
        begin
          acc = (q.cw_pos == 10'h000) ? b : (q.acc ^ b);
          n.acc = acc;
          k = CHECK_BASE + int'(q.cw);
          if (cw_end && q.ecc_en && ((acc ^ 8'hff) != q.mem[pg][k]))
            n.ecc_bad = 1'b1; // R6
        end
        if (last)
        begin
          n.ecc_stat = q.ecc_bad ? ECC_FAIL : ECC_OK; // R6 R16
          ev[IRQ_ECC] = q.ecc_bad;
          if (q.op == OP_CACHE_READ)
            done = 1'b1;
          else
            n.st = E_D2C;
        end
      end
      E_D2C:
      begin
        n.cache[q.idx] = q.dreg[q.idx]; // R10
        if (last)
        begin
          if (q.op == OP_MOVE)
          begin
            n.st = E_C2D; // R11
            n.cur_row = q.dest;
            n.timer = 32'(PROG_CYCLES - 1);
          end
          else if (q.op == OP_CACHE_READ)
          begin
            n.st = E_A2D; // R12
            n.ecc_bad = 1'b0;
          end
          else
            done = 1'b1; // R14
        end
      end
      E_C2D:
      begin
        b = q.cache[q.idx];
        if (in_cw)
        begin
          acc = (q.cw_pos == 10'h000) ? b : (q.acc ^ b);
          n.acc = acc;
          if (cw_end)
            n.chk[q.cw] = acc ^ 8'hff; // R5
        end
        else if (q.ecc_en)
        begin
          k = int'(q.idx) - CHECK_BASE;
          b = (k < CW_COUNT) ? q.chk[k[1:0]] : 8'hff; // R3 R5
        end
        n.dreg[q.idx] = b; // R4
        if (last)
          n.st = E_D2A;
      end
      E_D2A:
      begin
        n.mem[pg][q.idx] = q.mem[pg][q.idx] & q.dreg[q.idx]; // R9
        if (last)
          n.st = E_WAIT;
      end
      E_ERASE:
      begin
        n.mem[erow[PAW-1:0]] = '1; // R9
        n.epg = q.epg + 6'h01;
        if (q.epg == 6'(PAGES_PER_BLOCK - 1))
          n.st = E_WAIT;
      end
      E_WAIT:
      begin
        if (q.timer == 32'h0)
          done = 1'b1; // R15
      end
      default:
        n.st = E_IDLE;
    endcase
    if (done)
    begin
      n.st = E_IDLE; // R19
      ev[IRQ_DONE] = 1'b1;
    end

    // APB register writes
    if (wr_acc && !unmapped)
    begin
      unique case (paddr)
        REG_CTRL:
          if (q.s2.io[2] || q.wmode == 2'h2)
            n.ecc_en = pwdata[0]; // R2 R13
        REG_CMD:
        begin
          if (busy || pwdata[2:0] == OP_NONE || pwdata[2:0] > OP_MOVE)
            ev[IRQ_REFUSED] = 1'b1;
          else
          begin
            n.op = snce_op_t'(pwdata[2:0]);
            n.cur_row = q.row;
            n.ecc_bad = 1'b0;
            n.epg = '0;
            unique case (pwdata[2:0])
              OP_READ, OP_MOVE: n.st = E_A2D;
              OP_CACHE_READ: n.st = E_D2C; // R12
              OP_PROGRAM:
              begin
                n.st = E_C2D;
                n.timer = 32'(PROG_CYCLES - 1); // R15
              end
              default:
              begin
                n.st = E_ERASE;
                n.timer = 32'(ERASE_CYCLES - 1); // R15
              end
            endcase
          end
        end
        REG_ROW: n.row = pwdata[ROW_W-1:0];
        REG_DEST: n.dest = pwdata[ROW_W-1:0];
        REG_IRQ_CLR: clr = pwdata[IRQ_W-1:0];
        REG_IRQ_EN: n.irq_en = pwdata[IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end
    n.irq_stat = (q.irq_stat & ~clr) | ev;

    // APB read data, captured in the setup cycle
    if (psel && !penable)
    begin
      unique case (paddr)
        REG_CTRL: rv[0] = q.ecc_en;
        REG_CMD: rv[2:0] = q.op;
        REG_ROW: rv[ROW_W-1:0] = q.row;
        REG_DEST: rv[ROW_W-1:0] = q.dest;
        REG_STATUS:
        begin
          rv[ST_BUSY] = busy; // R16 R19
          rv[ST_CBUSY] = cbusy;
          rv[ST_ECC +: 2] = q.ecc_stat;
        end
        REG_IRQ_STAT: rv[IRQ_W-1:0] = q.irq_stat;
        REG_IRQ_EN: rv[IRQ_W-1:0] = q.irq_en;
        default: rv = 32'h0;
      endcase
      n.rdata = rv;
    end

    // Serial link to the cache register
    if (q.s2.cs_n)
    begin
      n.lph = L_HDR;
      n.lbits = '0;
      n.wmode = 2'h0;
    end
    else if (!hold && rise)
    begin
      unique case (q.lph)
        L_HDR:
        begin
          n.hdr = {q.hdr[6:0], q.s2.io[0]};
          n.lbits = q.lbits + 5'h01;
          if (q.lbits == 5'h07)
          begin
            n.lph = L_ADDR;
            n.lbits = '0;
            n.lwrite = n.hdr[7];
            n.wmode = (n.hdr[5:4] == 2'h3) ? 2'h0 : n.hdr[5:4];
          end
        end
        L_ADDR:
        begin
          n.col = {q.col[COL_W-2:0], q.s2.io[0]}; // R17
          n.lbits = q.lbits + 5'h01;
          if (q.lbits == 5'h0f)
          begin
            n.lph = L_DATA;
            n.lbits = '0;
            n.obits = '0;
          end
        end
        L_DATA:
        begin
          if (q.lwrite)
          begin
            unique case (q.wmode)
              2'h1: sh = {q.shin[5:0], q.s2.io[1:0]};
              2'h2: sh = {q.shin[3:0], q.s2.io[3:0]}; // R13
              default: sh = {q.shin[6:0], q.s2.io[0]};
            endcase
            n.shin = sh;
            nb = q.lbits + {1'b0, wbits};
            n.lbits = nb;
            if (nb == 5'h08)
            begin
              n.lbits = '0;
              n.col = q.col + 12'h001;
              if (q.col <= COL_W'(LAST_COL) && !cbusy &&
                  !(q.ecc_en &&
                    q.col >= COL_W'(MAIN_BYTES + ECC_PROG_SPARE)))
                n.cache[q.col] = sh; // R3 R4 R17
            end
          end
        end
        default:
          n.lph = L_HDR;
      endcase
    end
    else if (!hold && fall && q.lph == L_DATA && !q.lwrite)
    begin
      if (q.obits == 4'h0)
      begin
        if (q.col > COL_W'(LAST_COL) || cbusy)
          n.shout = 8'hff; // R17
        else
          n.shout = q.cache[q.col];
        n.col = q.col + 12'h001;
        n.obits = 4'h8 - wbits;
      end
      else
      begin
        n.shout = q.shout << wbits;
        n.obits = q.obits - wbits;
      end
    end

    // Output lanes, registered
    n.io_out = 4'h0;
    n.io_oe = 4'h0;
    if (!q.s2.cs_n && !hold && n.lph == L_DATA && !n.lwrite)
    begin
      unique case (n.wmode)
        2'h1:
        begin
          n.io_out[1:0] = n.shout[7:6];
          n.io_oe = 4'b0011;
        end
        2'h2:
        begin
          n.io_out = n.shout[7:4]; // R13
          n.io_oe = 4'b1111;
        end
        default:
        begin
          n.io_out[1] = n.shout[7];
          n.io_oe = 4'b0010;
        end
      endcase
    end

    // Reset: array erased, power-on page load of row zero
    if (reset)
    begin
      n = '0;
      n.s1.cs_n = 1'b1;
      n.s2.cs_n = 1'b1;
      n.s3.cs_n = 1'b1;
      n.ecc_en = CTRL_ECC_RESET; // R2
      n.st = E_A2D; // R8
      n.op = OP_READ;
      n.mem = '1;
      n.cache = '1;
      n.dreg = '1;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= n;
  end
endmodule

// ### testbench/snce_props.sv
`timescale 1ns/1ps
module snce_props
  import snce_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and interrupt
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input wire logic irq
);
  logic [15:0] boot_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Cycles since reset release
  always_ff @(posedge clk)
  begin
    if (reset)
      boot_cnt <= 16'h0000;
    else if (boot_cnt != 16'hffff)
      boot_cnt <= boot_cnt + 16'h0001;
  end
  sequence acc;
    psel && penable;
  endsequence
  sequence rd_acc(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence rd_then_idle;
    psel && penable && !pwrite ##1 !psel;
  endsequence
  a_ready_always: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_unmapped: assert property (
    acc ##0 (paddr > 8'h1c || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (
    psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_err_idle: assert property (!penable |-> !pslverr)
    else $error("error outside access");
  a_boot_busy: assert property (
    rd_acc(REG_STATUS) ##0 boot_cnt < 16'd4300 |-> prdata[ST_BUSY])
    else $error("busy missing during boot load");
  a_clr_zero: assert property (rd_acc(REG_IRQ_CLR) |-> prdata == 0)
    else $error("clear register reads nonzero");
  a_rd_hold: assert property (rd_then_idle |-> $stable(prdata))
    else $error("read data moved after access");
  a_lane_map: assert property (
    io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  a_oe_idle: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("line driven while deselected");
  a_irq_mask: assert property (
    acc ##0 pwrite && paddr == REG_IRQ_EN && pwdata[2:0] == 3'h0
    |-> ##[1:2] !irq)
    else $error("interrupt stays up when masked");
  a_reset_quiet: assert property (
    $fell(reset) |-> !irq && io_oe == 4'h0 && prdata == 32'h0)
    else $error("outputs active after reset");
endmodule

// ### testbench/snce_host_model.sv
`timescale 1ns/1ps
module snce_host_model (
  // Clock
  input wire logic clk,
  // Link
  input wire logic [3:0] lines,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] h_val,
  output logic [3:0] h_oe
);
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_val = 4'h0;
    h_oe = 4'h0;
  end
  // One bit time: set with clock low, taken on the rise
  task bit_cyc(input logic [3:0] v, input logic [3:0] oe,
    output logic [3:0] s);
    h_val <= v;
    h_oe <= oe;
    repeat (8) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    s = lines;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
  endtask
  task frame(input logic wr, input logic [1:0] ln, input logic [11:0] col,
    input int n);
    logic [23:0] hdr;
    logic [3:0] s;
    logic [3:0] m;
    logic [7:0] b;
    int w;
    hdr = {wr, 1'b0, ln, 8'h00, col};
    w = (ln == 2'h1) ? 2 : (ln == 2'h2) ? 4 : 1;
    m = 4'((1 << w) - 1);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
      bit_cyc({3'b000, hdr[i]}, 4'h1, s);
    for (int j = 0; j < n; j++)
    begin
      b = wr ? wq.pop_front() : 8'h00;
      for (int k = 8 - w; k >= 0; k -= w)
      begin
        bit_cyc(4'(b >> k) & m, wr ? m : 4'h0, s);
        if (!wr)
          b = 8'((b << w) | (w == 1 ? {3'b000, s[1]} : s & m));
      end
      if (!wr)
        rq.push_back(b);
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    h_oe <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ### testbench/test_serial_nand_cache_ecc_core.sv
`timescale 1ns/1ps
module test_serial_nand_cache_ecc_core;
  import snce_pkg::*;
  localparam int OPC = 5000;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic sclk, cs_n, tog;
  logic [7:0] paddr, d0, d1;
  logic [31:0] pwdata, prdata, r, seed;
  logic [3:0] io_out, io_oe, h_val, h_oe, lines;
  int failures, comparisons, cyc, t0;
  // Released data lines toggle, control lines are pulled up
  assign lines = (io_oe & io_out) | (~io_oe & h_oe & h_val)
    | (~io_oe & ~h_oe & {2'b11, tog, tog});
  snce_core #(.PROG_CYCLES(OPC), .ERASE_CYCLES(OPC)) dut (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .io_in(lines),
    .io_out(io_out), .io_oe(io_oe), .irq(irq));
  snce_host_model host (.clk(clk), .lines(lines), .sclk(sclk),
    .cs_n(cs_n), .h_val(h_val), .h_oe(h_oe));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tog <= ~tog;
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      failures++;
      print_verdict();
    end
  end
  task print_verdict();
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Spare bytes 2110..2120 after a program with correction on
  function automatic logic [7:0] spare_exp(int i);
    case (i)
      0: return d0;
      1: return d1;
      5: return ~(d0 ^ d1);
      default: return 8'hff;
    endcase
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task idle();
    do apb(1'b0, REG_STATUS, 32'h0); while (r[ST_BUSY] !== 1'b0);
  endtask
  task rdc(input logic [7:0] e);
    chk({24'h0, host.rq.pop_front()}, {24'h0, e});
  endtask
  initial
  begin
    seed = 32'd85;
    tog = 1'b0;
    cyc = 0;
    failures = 0;
    comparisons = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r & 32'h1, 32'h1);
    idle();
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r & 32'h1, 32'h1);
    host.frame(1'b0, 2'h0, 12'd0, 2);
    repeat (2) rdc(8'hff);
    d0 = xs();
    d1 = xs();
    host.wq = '{d0, d1, xs(), xs()};
    host.frame(1'b1, 2'h2, 12'd2110, 2);
    host.frame(1'b1, 2'h1, 12'd2120, 2);
    apb(1'b1, REG_ROW, 32'h1);
    apb(1'b1, REG_CMD, 32'h3);
    idle();
    t0 = cyc;
    apb(1'b1, REG_CMD, 32'h1);
    idle();
    chk(r & 32'hc, 32'h0);
    chk({31'h0, cyc - t0 <= 80 * CLK_MHZ}, 32'h1);
    host.frame(1'b0, 2'h1, 12'd2110, 11);
    for (int i = 0; i < 11; i++)
      rdc(spare_exp(i));
    apb(1'b1, REG_DEST, 32'h2);
    apb(1'b1, REG_CMD, 32'h5);
    idle();
    apb(1'b1, REG_ROW, 32'h2);
    apb(1'b1, REG_CMD, 32'h1);
    idle();
    host.frame(1'b0, 2'h2, 12'd2110, 1);
    rdc(d0);
    apb(1'b1, REG_CTRL, 32'h0);
    d0 = xs();
    d1 = xs();
    host.wq = '{d0, d1, xs(), xs()};
    host.frame(1'b1, 2'h0, 12'd2174, 4);
    host.frame(1'b0, 2'h0, 12'd2174, 4);
    for (int i = 0; i < 4; i++)
      rdc(i == 0 ? d0 : i == 1 ? d1 : 8'hff);
    // Cache read: cache takes the data register, then the row reloads
    apb(1'b1, REG_CMD, 32'h2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r & 32'h3, 32'h3);
    idle();
    apb(1'b0, REG_CMD, 32'h0);
    chk(r, 32'h2);
    host.frame(1'b0, 2'h0, 12'd2174, 1);
    rdc(8'hff);
    // Bad check byte programmed with correction off, then loaded with it on
    host.wq = '{8'h00};
    host.frame(1'b1, 2'h0, 12'd2112, 1);
    apb(1'b1, REG_ROW, 32'h3);
    apb(1'b1, REG_CMD, 32'h3);
    idle();
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_CMD, 32'h1);
    idle();
    chk(r & 32'hc, 32'h8);
    apb(1'b1, REG_IRQ_EN, 32'h7);
    apb(1'b0, REG_IRQ_CLR, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk({r[31:1], irq}, 32'h0);
    apb(1'b1, REG_CMD, 32'h4);
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk({r[2], irq}, 32'h3);
    idle();
    apb(1'b1, REG_CMD, 32'h1);
    idle();
    host.frame(1'b0, 2'h0, 12'd2110, 1);
    rdc(8'hff);
    apb(1'b1, REG_IRQ_EN, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    apb(1'b1, REG_CMD, 32'h7);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(r, 32'h4);
    print_verdict();
  end
endmodule
bind snce_core snce_props u_props (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
  .io_oe(io_oe), .irq(irq));
